// ==== nri_cfg.svh ====
// constants for the nand reset and identification block
`ifndef NRI_CFG_SVH
`define NRI_CFG_SVH
`define NRI_OFF_CTRL      8'h00
`define NRI_OFF_STAT      8'h04
`define NRI_OFF_FLAG      8'h08
`define NRI_OFF_UID_HI    4'h1
`define NRI_CTRL_GO       0
`define NRI_CTRL_LUN      1
`define NRI_CTRL_KIND     2
`define NRI_RESP_OK       2'h0
`define NRI_RESP_ERR      2'h2
`define NRI_CMD_RESET     8'hff
`define NRI_CMD_LUN_RST   8'hfa
`define NRI_CMD_READ_ID   8'h90
`define NRI_CMD_UID       8'hed
`define NRI_CMD_STATUS    8'h70
`define NRI_CMD_READ      8'h00
`define NRI_CMD_RND       8'h05
`define NRI_CMD_RND_GO    8'he0
`define NRI_ADR_ID        8'h00
`define NRI_ADR_SIG       8'h20
`define NRI_SIG0          8'h4f
`define NRI_SIG1          8'h4e
`define NRI_SIG2          8'h46
`define NRI_SIG3          8'h49
`define NRI_STAT_RESET    8'he0
`define NRI_STAT_WP       7
`define NRI_STAT_RDY      6
`define NRI_STAT_ARDY     5
`define NRI_CLK_NS        20
`define NRI_T_RST_NS      5000
`define NRI_RST_CYC       ((`NRI_T_RST_NS + `NRI_CLK_NS - 1) / `NRI_CLK_NS)
`define NRI_T_OP_NS       20000
`define NRI_OP_CYC        ((`NRI_T_OP_NS + `NRI_CLK_NS - 1) / `NRI_CLK_NS)
`define NRI_CNT_W         12
`define NRI_LUNS          2
`define NRI_LUN_BIT       0
`define NRI_ROW_LAST      2'h2
`define NRI_UID_BYTES     16
`define NRI_UID_CMP_BIT   4
`define NRI_IDX_W         9
`define NRI_ID3_INIT      '{cache:1'b1, ilv:1'b0, pages:2'h0, cells:2'h0, dies:2'h0}
`define NRI_ID4_INIT      '{acc_hi:1'b1, org16:1'b0, blk:2'h1, acc_lo:1'b0, spare16:1'b1, page:2'h1}
`define NRI_ID5_INIT      '{ecc_on:1'b0, rsv:3'b101, planes:2'h1, ecc:2'h2}
`endif

// ==== nri_pkg.sv ====
// types for the nand reset and identification block
package nri_pkg;
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_enable_n;
    logic       wp_n;
    logic [7:0] io;
  } nri_pin_s;
  typedef enum logic [2:0] {md_idle, md_id_addr, md_id, md_sig, md_uid_addr, md_uid, md_lun_addr} nri_mode_e;
  typedef enum logic [1:0] {op_none, op_read, op_prog, op_erase} nri_op_e;
  typedef struct packed {
    logic       cache;
    logic       ilv;
    logic [1:0] pages;
    logic [1:0] cells;
    logic [1:0] dies;
  } nri_id3_s;
  typedef struct packed {
    logic       acc_hi;
    logic       org16;
    logic [1:0] blk;
    logic       acc_lo;
    logic       spare16;
    logic [1:0] page;
  } nri_id4_s;
  typedef struct packed {
    logic       ecc_on;
    logic [2:0] rsv;
    logic [1:0] planes;
    logic [1:0] ecc;
  } nri_id5_s;
endpackage

// ==== nri_core.sv ====
// nand command interpreter for reset, lun reset, id, signature and unique id reads
// How it works
// - command ffh resets the device
// - reset aborts busy read, program or erase
// - aborted program or erase marks contents invalid
// - reset clears command, status reads e0h with wp_n high
// - reset accepted again while still resetting
// - ready/busy low for reset time, then high
// - fah plus row address resets one lun
// - 90h then address 00h enters id mode
// - five id bytes: maker, part, then characteristics
// - id mode held until next command
// - bytes four/five give geometry, ecc, planes
// - third byte: dies, cells, pages, ilv, cache
// - fourth byte: page, spare, access, block, width
// - fifth byte: ecc, planes, reserved 101, ecc on
// - 90h with 20h returns onfi signature
// - edh reads sixteen byte unique identifier
// - identifier then its bitwise complement
// - sixteen copies follow on continued reading
// - after status 70h, 00h resumes identifier
`timescale 1ns/100ps
`default_nettype none
`include "nri_cfg.svh"
module nri_core #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3c   // arbitrary value
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire nri_pkg::nri_pin_s nand_in,
  output logic [7:0]            io_out,
  output logic                  io_oe,
  output logic                  ready_busy,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import nri_pkg::*;

  localparam nri_id3_s ID3 = `NRI_ID3_INIT;
  localparam nri_id4_s ID4 = `NRI_ID4_INIT;
  localparam nri_id5_s ID5 = `NRI_ID5_INIT;

  nri_pin_s                pin_s0_q;
  nri_pin_s                pin_s1_q;
  nri_pin_s                pin_d_q;
  nri_mode_e               mode_q;
  logic                    stat_view_q;
  logic                    rnd_pend_q;
  logic [1:0]              adr_cnt_q;
  logic [`NRI_IDX_W-1:0]   col_q;
  logic [`NRI_IDX_W-1:0]   idx_q;
  logic                    lun_rst_q;
  logic                    lun_sel_q;
  logic [`NRI_CNT_W-1:0]   rst_cnt_q;
  logic [7:0]              status_q;
  logic [`NRI_LUNS-1:0]    lun_busy;
  logic [`NRI_LUNS-1:0]    inv_flag;
  logic [`NRI_LUNS-1:0]    abort_prog;
  logic [127:0]            uid_w;
  logic [7:0]              byte_sel;
  logic                    aw_have_q;
  logic                    w_have_q;
  logic [7:0]              waddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic [31:0]             rd_mux;
  logic                    rd_bad;

  // pins come from the host's clock domain: two stages before use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s0_q <= '1;
      pin_s1_q <= '1;
      pin_d_q  <= '1;
    end else begin
      pin_s0_q <= nand_in;
      pin_s1_q <= pin_s0_q;
      pin_d_q  <= pin_s1_q;
    end
  end

  wire [7:0] bus      = pin_s1_q.io;
  wire       sel      = ~pin_s1_q.ce_n;
  wire       we_rise  = pin_s1_q.we_n & ~pin_d_q.we_n & sel;
  wire       re_fall  = ~pin_s1_q.read_enable_n & pin_d_q.read_enable_n & sel;
  wire       cmd_stb  = we_rise & pin_s1_q.cle & ~pin_s1_q.ale;
  wire       resetting = rst_cnt_q != '0;
  wire       cmd_ff   = cmd_stb & (bus == `NRI_CMD_RESET);
  // while resetting only another reset gets through
  wire       cmd_go   = cmd_stb & (~resetting | cmd_ff);
  wire       adr_go   = we_rise & pin_s1_q.ale & ~pin_s1_q.cle & ~resetting;
  wire       data_md  = (mode_q == md_id) | (mode_q == md_sig) | (mode_q == md_uid);
  wire       rdy      = ~resetting & ~(|lun_busy);
  wire       wr_do    = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire       ctrl_wr  = wr_do & (waddr_q == `NRI_OFF_CTRL);
  wire       flag_wr  = wr_do & (waddr_q == `NRI_OFF_FLAG);
  wire       uid_wr   = wr_do & (waddr_q[7:4] == `NRI_OFF_UID_HI);

  // command and address decoding
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q      <= md_idle;
      stat_view_q <= 1'b0;
      rnd_pend_q  <= 1'b0;
      adr_cnt_q   <= 2'h0;
      col_q       <= '0;
      lun_rst_q   <= 1'b0;
      lun_sel_q   <= 1'b0;
    end else begin
      lun_rst_q <= 1'b0;
      if (cmd_ff) begin
        mode_q      <= md_idle;
        stat_view_q <= 1'b0;
        rnd_pend_q  <= 1'b0;
      end else if (cmd_go) begin
        case (bus)
          `NRI_CMD_LUN_RST: begin
            mode_q      <= md_lun_addr;
            adr_cnt_q   <= 2'h0;
            stat_view_q <= 1'b0;
          end
          `NRI_CMD_READ_ID: begin
            mode_q      <= md_id_addr;
            stat_view_q <= 1'b0;
          end
          `NRI_CMD_UID: begin
            mode_q      <= md_uid_addr;
            stat_view_q <= 1'b0;
          end
          `NRI_CMD_STATUS: stat_view_q <= 1'b1;
          `NRI_CMD_READ: begin
            // only the identifier read resumes after a status poll
            stat_view_q <= 1'b0;
            if (mode_q != md_uid) begin
              mode_q <= md_idle;
            end
          end
          `NRI_CMD_RND: begin
            rnd_pend_q <= 1'b1;
            adr_cnt_q  <= 2'h0;
            col_q      <= '0;
          end
          `NRI_CMD_RND_GO: begin
            rnd_pend_q  <= 1'b0;
            stat_view_q <= 1'b0;
          end
          default: begin
            mode_q      <= md_idle;
            stat_view_q <= 1'b0;
            rnd_pend_q  <= 1'b0;
          end
        endcase
      end else if (adr_go) begin
        if (rnd_pend_q) begin
          adr_cnt_q <= adr_cnt_q + 2'h1;
          if (adr_cnt_q == 2'h0) begin
            col_q[7:0] <= bus;
          end else begin
            col_q[`NRI_IDX_W-1] <= bus[0];
          end
        end else begin
          unique case (mode_q)
            md_id_addr: begin
              if (bus == `NRI_ADR_ID) begin
                mode_q <= md_id;
              end else if (bus == `NRI_ADR_SIG) begin
                mode_q <= md_sig;
              end else begin
                mode_q <= md_idle;
              end
            end
            md_uid_addr: mode_q <= md_uid;
            md_lun_addr: begin
              adr_cnt_q <= adr_cnt_q + 2'h1;
              if (adr_cnt_q == `NRI_ROW_LAST) begin
                lun_sel_q <= bus[`NRI_LUN_BIT];
                lun_rst_q <= 1'b1;
                mode_q    <= md_idle;
              end
            end
            md_idle, md_id, md_sig, md_uid: mode_q <= mode_q;
          endcase
        end
      end
    end
  end

  // byte index of the read stream
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= '0;
    end else if (adr_go & ~rnd_pend_q & ((mode_q == md_id_addr) | (mode_q == md_uid_addr))) begin
      idx_q <= '0;
    end else if (cmd_go & (bus == `NRI_CMD_RND_GO) & rnd_pend_q) begin
      idx_q <= col_q;
    end else if (re_fall & ~stat_view_q & data_md) begin
      idx_q <= idx_q + 1'b1;  // wraps after the sixteenth copy
    end
  end

  // reset busy timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_q <= '0;
    end else if (cmd_ff) begin
      rst_cnt_q <= `NRI_CNT_W'(`NRI_RST_CYC);
    end else if (resetting) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end
  end

  // status has no fail bits left after reset, so it reads e0h when ready with wp_n high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q   <= '0;
      ready_busy <= 1'b0;
    end else begin
      status_q                 <= '0;
      status_q[`NRI_STAT_WP]   <= pin_s1_q.wp_n;
      status_q[`NRI_STAT_RDY]  <= rdy;
      status_q[`NRI_STAT_ARDY] <= rdy;
      ready_busy               <= rdy;
    end
  end

  // array operations per lun, started by software to stand in for the array
  for (genvar l = 0; l < `NRI_LUNS; l++) begin : g_lun
    logic [`NRI_CNT_W-1:0] cnt_q;
    nri_op_e               kind_q;
    logic                  inv_q;
    wire abort = cmd_ff | (lun_rst_q & (lun_sel_q == 1'(l)));
    wire start = ctrl_wr & wdata_q[`NRI_CTRL_GO] & ~resetting
                 & (wdata_q[`NRI_CTRL_LUN] == 1'(l));
    assign abort_prog[l] = abort & (cnt_q != '0) & ((kind_q == op_prog) | (kind_q == op_erase));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt_q  <= '0;
        kind_q <= op_none;
      end else if (abort) begin
        cnt_q  <= '0;
        kind_q <= op_none;
      end else if (start & (cnt_q == '0)) begin
        cnt_q  <= `NRI_CNT_W'(`NRI_OP_CYC);
        kind_q <= nri_op_e'(wdata_q[`NRI_CTRL_KIND +: 2]);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
    // set wins over the software clear
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        inv_q <= 1'b0;
      end else begin
        inv_q <= abort_prog[l] | (inv_q & ~(flag_wr & wstrb_q[0] & wdata_q[l]));
      end
    end
    assign lun_busy[l] = cnt_q != '0;
    assign inv_flag[l] = inv_q;
  end

  // identifier storage, written by software a word at a time, each byte lane under its own strobe
  for (genvar b = 0; b < `NRI_UID_BYTES; b++) begin : g_uid
    logic [7:0] byte_q;
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        byte_q <= '0;
      end else if (uid_wr & (waddr_q[3:2] == 2'(b / 4)) & wstrb_q[b % 4]) begin
        byte_q <= wdata_q[8 * (b % 4) +: 8];
      end
    end
    assign uid_w[8 * b +: 8] = byte_q;
  end

  always_comb begin
    byte_sel = 8'h00;
    if (stat_view_q) begin
      byte_sel = status_q;
    end else begin
      unique case (mode_q)
        md_id: begin
          case (idx_q)
            9'h000:  byte_sel = MAKER_CODE;
            9'h001:  byte_sel = PART_CODE;
            9'h002:  byte_sel = ID3;
            9'h003:  byte_sel = ID4;
            9'h004:  byte_sel = ID5;
            default: byte_sel = 8'h00;
          endcase
        end
        md_sig: begin
          // past the fourth byte the host must not care what it sees
          case (idx_q)
            9'h000:  byte_sel = `NRI_SIG0;
            9'h001:  byte_sel = `NRI_SIG1;
            9'h002:  byte_sel = `NRI_SIG2;
            9'h003:  byte_sel = `NRI_SIG3;
            default: byte_sel = 8'h00;
          endcase
        end
        md_uid: begin
          byte_sel = uid_w[{idx_q[3:0], 3'h0} +: 8] ^ {8{idx_q[`NRI_UID_CMP_BIT]}};
        end
        md_idle, md_id_addr, md_uid_addr, md_lun_addr: byte_sel = 8'h00;
      endcase
    end
  end

  // output byte changes on the falling read strobe, one per strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_out <= 8'h00;
      io_oe  <= 1'b0;
    end else begin
      io_oe <= sel & ~pin_s1_q.read_enable_n & (stat_view_q | data_md);
      if (re_fall & (stat_view_q | data_md)) begin
        io_out <= byte_sel;
      end
    end
  end

  // axi write: address and data taken in either order, answer after both
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      waddr_q       <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `NRI_RESP_OK;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_q       <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ctrl_wr | flag_wr | uid_wr | (waddr_q == `NRI_OFF_STAT))
                        ? `NRI_RESP_OK : `NRI_RESP_ERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    rd_bad = 1'b0;
    if (s_axi_araddr[7:4] == `NRI_OFF_UID_HI) begin
      rd_mux = uid_w[{s_axi_araddr[3:2], 5'h00} +: 32];
    end else if ({s_axi_araddr[7:2], 2'h0} == `NRI_OFF_STAT) begin
      rd_mux = {21'h0, lun_busy, ready_busy, status_q};
    end else if ({s_axi_araddr[7:2], 2'h0} == `NRI_OFF_FLAG) begin
      rd_mux = {30'h0, inv_flag};
    end else if ({s_axi_araddr[7:2], 2'h0} != `NRI_OFF_CTRL) begin
      rd_bad = 1'b1;
    end
  end

  // axi read: one outstanding, answer the cycle after the address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `NRI_RESP_OK;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_bad ? `NRI_RESP_ERR : `NRI_RESP_OK;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_reset_abort: assert property (cmd_ff |=> lun_busy == '0)
    else $error("reset left an array operation running");
  chk_abort_invalid: assert property (abort_prog[0] |=> inv_flag[0])
    else $error("aborted program or erase not flagged invalid");
  chk_status_clear: assert property ($fell(resetting) && pin_s1_q.wp_n && lun_busy == '0
    |=> status_q == `NRI_STAT_RESET)
    else $error("status not e0h after reset");
  chk_reset_again: assert property (resetting && cmd_ff
    |=> rst_cnt_q == `NRI_CNT_W'(`NRI_RST_CYC))
    else $error("second reset not taken while resetting");
  chk_busy_low: assert property (cmd_ff |=> ##1 !ready_busy ##1 !ready_busy)
    else $error("ready/busy did not drop after reset");
  chk_busy_release: assert property (rst_cnt_q == `NRI_CNT_W'(1) && !cmd_ff
    |=> ##1 ready_busy)
    else $error("ready/busy not released after reset time");
  // lun 1 finishing on its own in the same cycle is not a fault
  chk_lun_only: assert property (lun_rst_q && !lun_sel_q && !cmd_ff && !ctrl_wr
    && g_lun[1].cnt_q != `NRI_CNT_W'(1)
    |=> lun_busy[1] == $past(lun_busy[1]))
    else $error("lun reset touched the other lun");
  chk_id_enter: assert property (adr_go && !rnd_pend_q && mode_q == md_id_addr
    && bus == `NRI_ADR_ID |=> mode_q == md_id && idx_q == '0)
    else $error("id mode not entered");
  chk_id_hold: assert property (mode_q == md_id && !cmd_go |=> mode_q == md_id)
    else $error("id mode left without a command");
  chk_maker_first: assert property (re_fall && !stat_view_q && mode_q == md_id
    && idx_q == '0 |=> io_out == MAKER_CODE && idx_q == 9'h001)
    else $error("maker code not first");
  chk_sig_first: assert property (re_fall && !stat_view_q && mode_q == md_sig
    && idx_q == '0 |=> io_out == `NRI_SIG0)
    else $error("signature does not start with 4fh");
  chk_uid_cmp: assert property (re_fall && !stat_view_q && mode_q == md_uid
    |=> io_out == (uid_w[{$past(idx_q[3:0]), 3'h0} +: 8] ^ {8{$past(idx_q[4])}}))
    else $error("identifier byte or complement wrong");
  chk_resume: assert property (stat_view_q && mode_q == md_uid && cmd_go
    && bus == `NRI_CMD_READ |=> !stat_view_q && mode_q == md_uid)
    else $error("identifier read not resumed by 00h");

  cov_reset_abort: cover property (abort_prog[0] ##[1:300] !resetting);
  cov_id_read: cover property (mode_q == md_id && idx_q == 9'h005);
  cov_uid_copy: cover property (mode_q == md_uid && idx_q == 9'h020);
  cov_lun_reset: cover property (lun_rst_q && lun_sel_q);
endmodule
`default_nettype wire

// ==== nri_host_model.sv ====
// host nand controller model: command, address and read-strobe cycles
`timescale 1ns/100ps
`default_nettype none
module nri_host_model (
  input  wire logic             clk,
  output var nri_pkg::nri_pin_s pins,
  input  wire logic [7:0]       io_out,
  input  wire logic             io_oe
);
  import nri_pkg::*;
  // idle levels; wp_n stays high so a status read shows e0h
  initial pins = '{ce_n:1'b1, cle:1'b0, ale:1'b0, we_n:1'b1, read_enable_n:1'b1,
                   wp_n:1'b1, io:8'h00};
  // levels held 4 clk: the device sees the pins through a 2-flop synchroniser
  task automatic wr_cyc(input logic c, input logic [7:0] d);
    @(posedge clk);
    pins <= '{ce_n:1'b0, cle:c, ale:!c, we_n:1'b0, read_enable_n:1'b1, wp_n:1'b1, io:d};
    repeat (4) @(posedge clk);
    pins.we_n <= 1'b1;
    repeat (4) @(posedge clk);
    // released bus shows the inverse, so a stale byte cannot pass for a fresh one
    pins <= '{ce_n:1'b0, cle:1'b0, ale:1'b0, we_n:1'b1, read_enable_n:1'b1, wp_n:1'b1, io:~d};
  endtask
  task automatic rd_cyc(output logic [7:0] d);
    @(posedge clk);
    pins.read_enable_n <= 1'b0;
    repeat (6) @(posedge clk);
    d = io_oe ? io_out : 8'hxx;
    pins.read_enable_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== nand_reset_and_id_readout_tb.sv ====
// self-checking bench for the nand reset and identification block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module nand_reset_and_id_readout_tb;
  import nri_pkg::*;
  localparam logic [7:0] MAKER = 8'ha7; // arbitrary value
  localparam logic [7:0] PART  = 8'h19; // arbitrary value
  logic        clk = 1'b0, rst_b = 1'b0;
  nri_pin_s    pins;
  logic [7:0]  io_out, d8, awaddr = 8'h00, araddr = 8'h00;
  logic        io_oe, ready_busy, awready, wready, bvalid, arready, rvalid;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] rdata, d32, wdata = 32'h0;
  logic [1:0]  bresp, rresp, resp;
  int          error_cnt = 0, num_checks = 0;
  always #10 clk = ~clk;
  nri_core #(.MAKER_CODE(MAKER), .PART_CODE(PART)) nri_core_i (.clk(clk), .rst_b(rst_b),
    .nand_in(pins), .io_out(io_out), .io_oe(io_oe), .ready_busy(ready_busy),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  nri_host_model nri_host_model_i (.clk(clk), .pins(pins), .io_out(io_out), .io_oe(io_oe));
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one bus transfer; each channel released only at its own handshake edge
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid || rvalid) begin
        d32 = rdata;
        resp = wr ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic cmd(input logic [7:0] c); nri_host_model_i.wr_cyc(1'b1, c); endtask
  task automatic adr(input logic [7:0] c); nri_host_model_i.wr_cyc(1'b0, c); endtask
  task automatic rd_chk(input logic [7:0] e); nri_host_model_i.rd_cyc(d8); `CHK(d8, e) endtask
  function automatic logic [7:0] ub(input int k);
    return 8'(k * 37 + 5);
  endfunction
  // counts clk edges with busy sampled low, from the first one seen
  task automatic wait_low(output int n);
    n = 0;
    for (int k = 0; k < 20 && ready_busy; k++) @(posedge clk);
    for (int k = 0; k < 400 && !ready_busy; k++) begin
      n++;
      @(posedge clk);
    end
    if (!ready_busy) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic t_regs();
    axi(1'b0, 8'h04, 32'h0);
    `CHK(d32, 32'h1e0)
    axi(1'b0, 8'h40, 32'h0);
    `CHK(resp, 2'h2)
    axi(1'b1, 8'h04, 32'h0);
    `CHK(resp, 2'h0)
  endtask
  task automatic t_info();
    logic [7:0] e [5];
    logic [7:0] s [4];
    e = '{MAKER, PART, 8'h80, 8'h95, 8'h56};
    s = '{8'h4f, 8'h4e, 8'h46, 8'h49};
    cmd(8'h90);
    adr(8'h00);
    foreach (e[k]) rd_chk(e[k]);
    cmd(8'h90);
    adr(8'h20);
    // only four bytes read: the rest is undefined
    foreach (s[k]) rd_chk(s[k]);
  endtask
  task automatic t_reset();
    int n;
    // read, program and erase each aborted in flight
    for (int k = 1; k < 4; k++) begin
      axi(1'b1, 8'h00, 32'(k * 4 + 1));
      axi(1'b0, 8'h04, 32'h0);
      `CHK(d32[9], 1'b1)
      cmd(8'hff);
      wait_low(n);
      `CHK(n, 251) // busy already low from the op, so the strobe's edge counts
      axi(1'b0, 8'h04, 32'h0);
      `CHK(d32, 32'h1e0)
      axi(1'b0, 8'h08, 32'h0);
      `CHK(d32, 32'(k > 1))
      axi(1'b1, 8'h08, 32'h3);
    end
    cmd(8'h70);
    rd_chk(8'he0);
    cmd(8'hff);
    repeat (60) @(posedge clk);
    cmd(8'hff);
    wait_low(n);
    `CHK((n > 240 && n < 260), 1'b1)
  endtask
  task automatic t_uniq();
    for (int i = 0; i < 4; i++)
      axi(1'b1, 8'(16 + 4 * i), {ub(4 * i + 3), ub(4 * i + 2), ub(4 * i + 1), ub(4 * i)});
    cmd(8'hed);
    adr(8'h00);
    for (int k = 0; k < 33; k++) rd_chk(k[4] ? ~ub(k % 16) : ub(k % 16));
    cmd(8'h70);
    rd_chk(8'he0);
    cmd(8'h00);
    rd_chk(ub(1));
    cmd(8'h05);
    adr(8'h11);
    adr(8'h00);
    cmd(8'he0);
    rd_chk(~ub(1));
  endtask
  task automatic t_lun();
    axi(1'b1, 8'h00, 32'h9);
    axi(1'b1, 8'h00, 32'hb);
    cmd(8'hfa);
    adr(8'h00);
    adr(8'h00);
    adr(8'h01);
    `CHK(ready_busy, 1'b0) // lun 0 still busy, no reset pulse
    axi(1'b0, 8'h04, 32'h0);
    `CHK(d32[10:9], 2'b01)
    axi(1'b0, 8'h08, 32'h0);
    `CHK(d32, 32'h2)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_info();
    t_reset();
    t_uniq();
    t_lun();
    print_verdict();
  end
endmodule
`default_nettype wire
